// ===== mct_map.vh
// Address map, field positions and reset values of the five-channel timer
`ifndef MCT_MAP_VH
`define MCT_MAP_VH

// Channel windows: channel n occupies byte offsets n*0x20 .. n*0x20+0x1F
`define MCT_CH_SPAN 8'h20
`define MCT_NUM_CH 5
// Word offsets inside a channel window (paddr[4:2])
`define MCT_OFF_CTRL 3'h0
`define MCT_OFF_COUNT 3'h1
`define MCT_OFF_REGA 3'h2
`define MCT_OFF_REGC 3'h3
`define MCT_OFF_STATUS 3'h4
`define MCT_OFF_IEN 3'h5
// Global window (paddr[7:5] == 5)
`define MCT_GLB_SEL 3'h5
`define MCT_OFF_GCTRL 3'h0
`define MCT_OFF_DEAD 3'h1
`define MCT_OFF_CDR 3'h2
`define MCT_OFF_CDB 3'h3

// Channel control fields
`define MCT_CTRL_START 0
`define MCT_CTRL_DOWN 1
`define MCT_CTRL_CLR_MATCH 2
`define MCT_CTRL_BUF_A 3
`define MCT_CTRL_CAPTURE 4
`define MCT_CTRL_CASCADE 5
`define MCT_CTRL_CAP_CH1CLK 6
`define MCT_CTRL_W 7

// Status and interrupt-enable fields
`define MCT_ST_MATCH 0
`define MCT_ST_OVF 1
`define MCT_ST_UNF 2
`define MCT_ST_W 3

// Global control fields
`define MCT_G_STANDBY 0
`define MCT_G_CPWM 1

// Reset values
`define MCT_GCTRL_RST 2'h1
`define MCT_CTRL_RST 7'h00
`define MCT_CNT_MAX 16'hFFFF
`define MCT_CNT_ZERO 16'h0000
`define MCT_REG_RST 16'hFFFF

`endif

// ===== mct_timer.v
// Five-channel 16-bit timer with flags, buffers and access contention, APB slave
//
// Notes on behaviour
// [R1] Count rollover from FFFF to 0000 sets overflow flag and request.
// [R2] Underflow while counting down sets underflow flag and request.
// [R3] Compare match or capture on register A sets its flag and request.
// [R4] Flag clears by writing 0 only after it was read as 1.
// [R5] Transfer controller activation clears the match flag automatically.
// [R6] Reset leaves the unit in standby; registers locked until standby cleared.
// [R7] External count clock levels last 1.5 or 2.5 states minimum.
// [R8] Phase counting inputs need 1.5 state phase gap, 2.5 state width.
// [R9] Clear-on-match clears after the matching state; period is N+1.
// [R10] Clear during counter write cycle wins; written value dropped.
// [R11] Counter write beats a coincident increment.
// [R12] Register write and coincident compare match both take effect.
// [R13] Buffer transfer on write contention: channel 0 new value, 3/4 old.
// [R14] Read coinciding with capture returns the captured value.
// [R15] Capture beats a coincident register A write.
// [R16] Capture buffer transfer beats a coincident buffer write.
// [R17] Cascade: channel 2 write wins, channel 1 count pulse suppressed.
// [R18] Channel 1 match and channel 1 clock captures still occur then.
// [R19] Software sets counter clearing of cascaded channels consistently.
// [R20] Stopping complementary PWM: channel 3 gets dead time, channel 4 zero.
// [R21] Restarting complementary PWM resumes from the stop state.
// [R22] Complementary PWM buffers: 3C for 3A, 4C for 4A, cycle buffer.
// [R23] Software updates PWM cycle and duty only through buffers.
// [R24] Request is flag AND enable, withdrawn when the flag clears.
// [R25] Buffer mode: C to A on match, A to C on capture.
`timescale 1ns/10ps
`include "mct_map.vh"

module mct_timer #(
  parameter NCH = 5,
  parameter CW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Timer events
  input wire [NCH-1:0] capture_in,
  input wire [NCH-1:0] xfer_clear,
  // Interrupt requests
  output wire [NCH-1:0] match_capture_irq,
  output wire [NCH-1:0] overflow_irq,
  output wire [NCH-1:0] underflow_irq
);

  function hit;
    input [7:0] addr;
    input [2:0] win;
    input [2:0] off;
    begin
      hit = (addr[7:5] == win) && (addr[4:2] == off) && (addr[1:0] == 2'h0);
    end
  endfunction

  // Zero-extends a register field to a bus word
  function [31:0] pad_word;
    input [CW-1:0] val;
    begin
      pad_word = {{(32-CW){1'b0}}, val};
    end
  endfunction

  // Channels with special roles
  localparam CH_CASC_LOW = 1;
  localparam CH_CASC_HIGH = 2;
  localparam CH_PAIR_LEAD = 3;
  localparam CH_PAIR_TAIL = 4;

  reg [1:0] gctrl_reg;
  reg [CW-1:0] dead_reg;
  reg [CW-1:0] cdr_reg;
  reg [CW-1:0] cdb_reg;

  wire standby = gctrl_reg[`MCT_G_STANDBY];
  wire cpwm = gctrl_reg[`MCT_G_CPWM];
  wire acc = psel && penable;
  wire setup = psel && !penable;
  wire wr = acc && pwrite;
  wire glb_hit = hit(paddr, `MCT_GLB_SEL, `MCT_OFF_GCTRL);
  wire ch_win = (paddr[7:5] < `MCT_GLB_SEL) && (paddr[4:2] <= `MCT_OFF_IEN) &&
    (paddr[1:0] == 2'h0);
  wire glb_win = (paddr[7:5] == `MCT_GLB_SEL) && (paddr[4:2] <= `MCT_OFF_CDB) &&
    (paddr[1:0] == 2'h0);
  // Only the standby control stays reachable while in standby
  wire locked = standby && !glb_hit; // [R6]

  assign pready = 1'b1;
  assign pslverr = acc && (!(ch_win || glb_win) || locked); // [R6]

  // Flattened per-channel state, next values and cross-channel events
  wire [NCH*`MCT_CTRL_W-1:0] ctrl_f;
  wire [NCH*CW-1:0] cnt_n;
  wire [NCH*CW-1:0] rega_n;
  wire [NCH*CW-1:0] regc_n;
  wire [NCH*`MCT_ST_W-1:0] flag_n;
  wire [NCH*`MCT_ST_W-1:0] ien_f;
  wire [NCH-1:0] tick_raw;
  wire [NCH-1:0] carry_raw;
  wire [NCH-1:0] cnt_wr;
  wire [NCH-1:0] match_ev;

  // Complementary PWM stop: channel 3 start bit written to 0
  wire cpwm_stop = cpwm && wr && !locked && hit(paddr, 3'h3, `MCT_OFF_CTRL) &&
    ctrl_f[3*`MCT_CTRL_W+`MCT_CTRL_START] && !pwdata[`MCT_CTRL_START];

  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      reg [`MCT_CTRL_W-1:0] ctrl_reg;
      reg [CW-1:0] cnt_reg;
      reg [CW-1:0] rega_reg;
      reg [CW-1:0] regc_reg;
      reg [`MCT_ST_W-1:0] flag_reg;
      reg [`MCT_ST_W-1:0] armed_reg;
      reg [`MCT_ST_W-1:0] ien_reg;
      reg [CW-1:0] cnt_next;
      reg [CW-1:0] rega_next;
      reg [CW-1:0] regc_next;
      reg [`MCT_ST_W-1:0] flag_next;
      reg [`MCT_ST_W-1:0] armed_next;

      wire [31:0] win_full = i;
      wire [2:0] win = win_full[2:0];
      wire ok = wr && !locked;
      wire w_ctrl = ok && hit(paddr, win, `MCT_OFF_CTRL);
      wire w_cnt = ok && hit(paddr, win, `MCT_OFF_COUNT);
      wire w_a = ok && hit(paddr, win, `MCT_OFF_REGA);
      wire w_c = ok && hit(paddr, win, `MCT_OFF_REGC);
      wire w_st = ok && hit(paddr, win, `MCT_OFF_STATUS);
      wire w_ien = ok && hit(paddr, win, `MCT_OFF_IEN);
      wire r_st = setup && !pwrite && !locked &&
        hit(paddr, win, `MCT_OFF_STATUS);

      wire in_pair = cpwm && (i == CH_PAIR_LEAD || i == CH_PAIR_TAIL);
      wire down = ctrl_reg[`MCT_CTRL_DOWN] && !in_pair;
      wire casc = (i == CH_CASC_LOW) && ctrl_reg[`MCT_CTRL_CASCADE];
      wire run = (i == CH_PAIR_TAIL && cpwm) ?
        ctrl_f[CH_PAIR_LEAD*`MCT_CTRL_W+`MCT_CTRL_START] : ctrl_reg[`MCT_CTRL_START];
      wire buf_on = (i == CH_PAIR_TAIL && cpwm) ?
        ctrl_f[CH_PAIR_LEAD*`MCT_CTRL_W+`MCT_CTRL_BUF_A] : ctrl_reg[`MCT_CTRL_BUF_A]; // [R22]

      wire cap_mode = ctrl_reg[`MCT_CTRL_CAPTURE];

      // Cascaded channel 1 counts on channel 2 carry instead of the clock
      wire traw = !standby && (casc ? carry_raw[CH_CASC_HIGH] : run); // [R6]
      // Channel 1 count pulse dropped when the channel 2 counter is written meanwhile
      wire casc_kill = casc && cnt_wr[CH_CASC_HIGH]; // [R17]
      wire equal = (cnt_reg == rega_reg);
      wire match = traw && equal && !cap_mode; // [R9] [R12] [R18]

      wire cap_src = ctrl_reg[`MCT_CTRL_CAP_CH1CLK] ? tick_raw[CH_CASC_LOW] : capture_in[i];
      wire cap = cap_mode && !standby && cap_src; // [R18]
      wire clr = match && ctrl_reg[`MCT_CTRL_CLR_MATCH]; // [R9]

      wire at_end = down ? (cnt_reg == `MCT_CNT_ZERO) : (cnt_reg == `MCT_CNT_MAX);
      wire tick = traw && !w_cnt && !casc_kill; // [R11] [R17]

      // Clearing takes precedence over the rollover flag
      wire ovf = tick && !down && at_end && !clr; // [R1]
      wire unf = tick && down && at_end && !clr; // [R2]

      wire [`MCT_ST_W-1:0] set = {unf, ovf, match || cap}; // [R3]
      wire [`MCT_ST_W-1:0] sw_clr = w_st ? (armed_reg & ~pwdata[`MCT_ST_W-1:0]) :
        {`MCT_ST_W{1'b0}}; // [R4]
      wire [`MCT_ST_W-1:0] xfer_clr = {2'h0, xfer_clear[i]}; // [R5]

      // Channel 0 moves the buffer value being written, channels 3 and 4 the old one
      wire [CW-1:0] buf_src = (i == 0 && w_c) ? pwdata[CW-1:0] : regc_reg; // [R13]

      assign tick_raw[i] = traw;
      assign carry_raw[i] = traw && at_end && !clr;
      assign cnt_wr[i] = w_cnt;
      assign match_ev[i] = match;

      always @* begin
        if (cpwm_stop && i == 3) begin
          cnt_next = dead_reg; // [R20]
        end else if (cpwm_stop && i == 4) begin
          cnt_next = `MCT_CNT_ZERO; // [R20]
        end else if (clr) begin
          cnt_next = `MCT_CNT_ZERO; // [R10]
        end else if (w_cnt) begin
          cnt_next = pwdata[CW-1:0]; // [R11] [R17]
        end else if (tick) begin
          cnt_next = down ? cnt_reg - 1'b1 : cnt_reg + 1'b1; // [R1] [R2]
        end else begin
          cnt_next = cnt_reg; // [R21]
        end
      end

      always @* begin
        if (cap) begin
          rega_next = cnt_reg; // [R15]
        end else if (match && buf_on) begin
          rega_next = buf_src; // [R25] [R22]
        end else if (w_a) begin
          rega_next = pwdata[CW-1:0]; // [R12]
        end else begin
          rega_next = rega_reg;
        end
      end

      always @* begin
        if (cap && buf_on) begin
          regc_next = rega_reg; // [R16] [R25]
        end else if (w_c) begin
          regc_next = pwdata[CW-1:0];
        end else begin
          regc_next = regc_reg;
        end
      end

      // A newly raised event beats a clear in the same cycle
      always @* begin
        flag_next = set | (flag_reg & ~(sw_clr | xfer_clr)); // [R4] [R5]
      end

      // Arm a clear only for flags seen as 1 by a status read
      always @* begin
        if (w_st) begin
          armed_next = {`MCT_ST_W{1'b0}}; // [R4]
        end else if (r_st) begin
          armed_next = flag_next; // [R4]
        end else begin
          armed_next = armed_reg & flag_next;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_reg <= `MCT_CTRL_RST;
          ien_reg <= {`MCT_ST_W{1'b0}};
        end else begin
          if (w_ctrl) begin
            ctrl_reg <= pwdata[`MCT_CTRL_W-1:0];
          end
          if (w_ien) begin
            ien_reg <= pwdata[`MCT_ST_W-1:0];
          end
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= `MCT_CNT_ZERO;
          rega_reg <= `MCT_REG_RST;
          regc_reg <= `MCT_REG_RST;
        end else begin
          cnt_reg <= cnt_next;
          rega_reg <= rega_next;
          regc_reg <= regc_next;
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_reg <= {`MCT_ST_W{1'b0}};
          armed_reg <= {`MCT_ST_W{1'b0}};
        end else begin
          flag_reg <= flag_next;
          armed_reg <= armed_next;
        end
      end

      assign ctrl_f[i*`MCT_CTRL_W +: `MCT_CTRL_W] = ctrl_reg;
      assign cnt_n[i*CW +: CW] = cnt_next;
      assign rega_n[i*CW +: CW] = rega_next;
      assign regc_n[i*CW +: CW] = regc_next;
      assign flag_n[i*`MCT_ST_W +: `MCT_ST_W] = flag_next;
      assign ien_f[i*`MCT_ST_W +: `MCT_ST_W] = ien_reg;

      // Requests follow flag and enable without delay
      assign match_capture_irq[i] = flag_reg[`MCT_ST_MATCH] &&
        ien_reg[`MCT_ST_MATCH]; // [R24]
      assign overflow_irq[i] = flag_reg[`MCT_ST_OVF] &&
        ien_reg[`MCT_ST_OVF]; // [R24]
      assign underflow_irq[i] = flag_reg[`MCT_ST_UNF] &&
        ien_reg[`MCT_ST_UNF]; // [R24]
    end
  endgenerate

  // Global registers; cycle buffer moves on channel 3 match in PWM pair mode
  wire gw = wr && (paddr[7:5] == `MCT_GLB_SEL);
  wire gw_open = gw && !locked;
  wire cdr_load = cpwm && match_ev[CH_PAIR_LEAD] &&
    ctrl_f[CH_PAIR_LEAD*`MCT_CTRL_W+`MCT_CTRL_BUF_A];

  // Standby control stays writable while everything else is locked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctrl_reg <= `MCT_GCTRL_RST; // [R6]
    end else if (gw && glb_hit) begin
      gctrl_reg <= pwdata[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_reg <= `MCT_CNT_ZERO;
    end else if (gw_open && hit(paddr, `MCT_GLB_SEL, `MCT_OFF_DEAD)) begin
      dead_reg <= pwdata[CW-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdb_reg <= `MCT_CNT_ZERO;
    end else if (gw_open && hit(paddr, `MCT_GLB_SEL, `MCT_OFF_CDB)) begin
      cdb_reg <= pwdata[CW-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdr_reg <= `MCT_CNT_ZERO;
    end else if (cdr_load) begin
      cdr_reg <= cdb_reg; // [R22]
    end else if (gw_open && hit(paddr, `MCT_GLB_SEL, `MCT_OFF_CDR)) begin
      cdr_reg <= pwdata[CW-1:0];
    end
  end

  // Read data sampled at the end of setup; count, A, C and status from next-state values, the rest from current values
  reg [31:0] rd_mux;
  integer k;
  always @* begin
    rd_mux = 32'h0000_0000;
    k = paddr[7:5];
    if (locked || paddr[1:0] != 2'h0) begin
      rd_mux = 32'h0000_0000; // [R6]
    end else if (paddr[7:5] == `MCT_GLB_SEL) begin
      case (paddr[4:2])
        `MCT_OFF_GCTRL: rd_mux = {30'h0, gctrl_reg};
        `MCT_OFF_DEAD: rd_mux = pad_word(dead_reg);
        `MCT_OFF_CDR: rd_mux = pad_word(cdr_reg);
        `MCT_OFF_CDB: rd_mux = pad_word(cdb_reg);
        default: rd_mux = 32'h0000_0000;
      endcase
    end else if (k < NCH) begin
      case (paddr[4:2])
        `MCT_OFF_CTRL: rd_mux = {25'h0, ctrl_f[k*`MCT_CTRL_W +: `MCT_CTRL_W]};
        `MCT_OFF_COUNT: rd_mux = pad_word(cnt_n[k*CW +: CW]);
        `MCT_OFF_REGA: rd_mux = pad_word(rega_n[k*CW +: CW]); // [R14]
        `MCT_OFF_REGC: rd_mux = pad_word(regc_n[k*CW +: CW]); // [R14]
        `MCT_OFF_STATUS: rd_mux = {29'h0, flag_n[k*`MCT_ST_W +: `MCT_ST_W]};
        `MCT_OFF_IEN: rd_mux = {29'h0, ien_f[k*`MCT_ST_W +: `MCT_ST_W]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule

// ===== mct_timer_props.sv
// Bus and flag checks for the five-channel timer
`timescale 1ns/10ps
module mct_timer_props #(
  parameter NCH = 5,
  parameter CW = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Events and requests
  input wire [NCH-1:0] capture_in,
  input wire [NCH-1:0] xfer_clear,
  input wire [NCH-1:0] match_capture_irq,
  input wire [NCH-1:0] overflow_irq,
  input wire [NCH-1:0] underflow_irq
);
  wire acc = psel & penable;
  wire wacc = acc & pwrite;
  wire rsetup = psel & ~penable & ~pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access cycle");
  a_err_window: assert property (pslverr |-> acc)
    else $error("pslverr outside access cycle");
  a_unmapped_err: assert property (acc && (paddr >= 8'hB0 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  a_gctrl_open: assert property (acc && paddr == 8'hA0 |-> !pslverr)
    else $error("global control refused");
  a_read_width: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_rdata_hold: assert property (!rsetup |=> $stable(prdata))
    else $error("read data changed without read setup");
  a_reset_quiet: assert property ($rose(presetn) |->
    (match_capture_irq == 0 && overflow_irq == 0 && underflow_irq == 0) [*2])
    else $error("request active right after reset");
  a_mirq_fall: assert property
    ((|($past(match_capture_irq) & ~match_capture_irq & ~$past(xfer_clear))) |-> $past(wacc))
    else $error("match request dropped without cause");
  a_cirq_fall: assert property ((|(($past(overflow_irq) & ~overflow_irq) |
    ($past(underflow_irq) & ~underflow_irq))) |-> $past(wacc))
    else $error("count request dropped without write");
endmodule

bind mct_timer mct_timer_props #(.NCH(NCH), .CW(CW)) i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_in(capture_in),
  .xfer_clear(xfer_clear), .match_capture_irq(match_capture_irq),
  .overflow_irq(overflow_irq), .underflow_irq(underflow_irq));

// ===== mct_host.sv
// Host model: bus master and transfer-controller clear pulses
`timescale 1ns/10ps
module mct_host (
  // Bus
  input wire pclk,
  output reg psel = 1'b0,
  output reg penable = 1'b0,
  output reg pwrite = 1'b0,
  output reg [7:0] paddr = 8'h00,
  output reg [31:0] pwdata = 32'h0000_0000,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Transfer controller
  output reg [4:0] xfer_clear = 5'h00
);
  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released data no longer shows the old value
      pwdata <= ~d;
    end
  endtask
  task pulse_clear(input [4:0] m);
    begin
      @(posedge pclk);
      xfer_clear <= m;
      @(posedge pclk);
      xfer_clear <= 5'h00;
    end
  endtask
endmodule

// ===== mct_timer_tb_top.sv
// Self-checking bench for the five-channel timer
`timescale 1ns/10ps
module mct_timer_tb_top;
  reg pclk;
  reg presetn = 1'b0;
  reg [4:0] capture_in = 5'h00;
  wire psel, penable, pwrite, pready, pslverr;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [4:0] xfer_clear, match_capture_irq, overflow_irq, underflow_irq;
  reg [31:0] q, x;
  reg e;
  integer i;
  integer err_total = 0;
  integer checks = 0;
  mct_timer i_mct_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in(capture_in), .xfer_clear(xfer_clear),
    .match_capture_irq(match_capture_irq), .overflow_irq(overflow_irq),
    .underflow_irq(underflow_irq));
  mct_host i_mct_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_clear(xfer_clear));
  task chk(input string nm, input [31:0] xp, input [31:0] got);
    begin
      checks = checks + 1;
      if (got !== xp) begin
        err_total = err_total + 1;
        $display("ERROR %0s expected %h seen %h", nm, xp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      i_mct_host.xfer(1'b1, a, d, q, e);
    end
  endtask
  task rd(input [7:0] a);
    begin
      i_mct_host.xfer(1'b0, a, 32'h0, q, e);
    end
  endtask
  task rck(input string nm, input [7:0] a, input [31:0] xp);
    begin
      rd(a);
      chk(nm, xp, q);
      chk("pslverr", 32'h0, {31'h0, e});
    end
  endtask
  task cap(input [4:0] m);
    begin
      @(posedge pclk);
      capture_in <= m;
      @(posedge pclk);
      capture_in <= 5'h00;
    end
  endtask
  task t_standby;
    begin
      rd(8'h04);
      chk("lock_err", 32'h1, {31'h0, e});
      rck("gctrl", 8'hA0, 32'h1);
      wr(8'hA0, 32'h0);
      rd(8'hB0);
      chk("unmap_err", 32'h1, {31'h0, e});
    end
  endtask
  task t_ovf;
    begin
      wr(8'h00, 32'h1);
      wr(8'h04, 32'h0100);
      rck("cnt_write", 8'h04, 32'h0102);
      wr(8'h04, 32'hFFF0);
      repeat (30) @(posedge pclk);
      wr(8'h00, 32'h0);
      @(negedge pclk);
      chk("ovf_masked", 32'h0, {31'h0, overflow_irq[0]});
      wr(8'h14, 32'h2);
      @(negedge pclk);
      chk("ovf_irq", 32'h1, {31'h0, overflow_irq[0]});
      wr(8'h10, 32'h0);
      @(negedge pclk);
      chk("unarmed_clr", 32'h1, {31'h0, overflow_irq[0]});
      rck("ovf_flag", 8'h10, 32'h3);
      wr(8'h10, 32'h0);
      @(negedge pclk);
      chk("armed_clr", 32'h0, {31'h0, overflow_irq[0]});
    end
  endtask
  task t_unf;
    begin
      wr(8'h24, 32'h5);
      wr(8'h34, 32'h4);
      wr(8'h20, 32'h3);
      repeat (20) @(posedge pclk);
      wr(8'h20, 32'h0);
      @(negedge pclk);
      chk("unf_irq", 32'h1, {31'h0, underflow_irq[1]});
      rck("unf_flag", 8'h30, 32'h5);
    end
  endtask
  task t_cap;
    begin
      wr(8'h44, 32'h1234);
      wr(8'h54, 32'h1);
      wr(8'h40, 32'h10);
      cap(5'h04);
      @(negedge pclk);
      chk("cap_irq", 32'h1, {31'h0, match_capture_irq[2]});
      rck("cap_val", 8'h48, 32'h1234);
      i_mct_host.pulse_clear(5'h04);
      @(negedge pclk);
      chk("xfer_clr", 32'h0, {31'h0, match_capture_irq[2]});
      wr(8'h44, 32'h5678);
      wr(8'h40, 32'h18);
      cap(5'h04);
      rck("buf_a", 8'h48, 32'h5678);
      rck("buf_c", 8'h4C, 32'h1234);
    end
  endtask
  task t_casc;
    begin
      rd(8'h30);
      wr(8'h30, 32'h0);
      wr(8'h28, 32'h7);
      wr(8'h24, 32'h7);
      wr(8'h20, 32'h20);
      wr(8'h44, 32'hFFFD);
      wr(8'h40, 32'h1);
      wr(8'h44, 32'h0100);
      rck("casc_ch2", 8'h44, 32'h0102);
      rck("casc_ch1", 8'h24, 32'h7);
      rck("casc_match", 8'h30, 32'h1);
    end
  endtask
  task t_pwmbuf;
    begin
      wr(8'h60, 32'h0);
      wr(8'h64, 32'h0);
      wr(8'h6C, 32'h20);
      wr(8'hAC, 32'h55);
      wr(8'h60, 32'h9);
      repeat (10) @(posedge pclk);
      rck("pwm_rega", 8'h68, 32'h20);
      rck("pwm_cdr", 8'hA8, 32'h55);
    end
  endtask
  task t_clr;
    begin
      wr(8'h68, 32'h4);
      wr(8'h60, 32'h5);
      rd(8'h64);
      for (i = 0; i < 5; i = i + 1) begin
        x = (q + 3) % 5;
        rd(8'h64);
        chk("clr_cnt", x, q);
      end
      rck("clr_flag", 8'h70, 32'h1);
      wr(8'h60, 32'h0);
    end
  endtask
  task t_cpwm;
    begin
      wr(8'hA0, 32'h2);
      wr(8'hA4, 32'h10);
      wr(8'h60, 32'h1);
      repeat (10) @(posedge pclk);
      wr(8'h60, 32'h0);
      rck("ch3_stop", 8'h64, 32'h10);
      rck("ch4_stop", 8'h84, 32'h0);
      wr(8'h60, 32'h1);
      rd(8'h64);
      chk("restart", 32'h1, {31'h0, q > 32'h10 && q < 32'h14});
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #3000000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_standby;
    t_ovf;
    t_unf;
    t_cap;
    t_casc;
    t_clr;
    t_cpwm;
    t_pwmbuf;
    summarize;
  end
endmodule
